// File: logic/param_rom.sv
// Purpose: serves a slice of discoverable parameter bytes with auto increment
// Assumes: command decode supplies a start address and a byte strobe
// Notes: data out is registered one cycle after load or advance
`timescale 1ns/1ps
`include "param_rom_consts.svh"
module param_rom
    import param_rom_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic i_space,
    input wire logic [15:0] i_addr,
    input wire logic i_next,
    output byte_t o_data,
    output logic o_valid,
    output logic [15:0] o_addr
);
    ////////////////////////////////////////////////////////////////////////////
    // address pointer
    logic [15:0] addr_r, addr_nxt;
    space_e space_r, space_nxt;
    byte_t data_r, data_nxt;
    logic valid_r, valid_nxt;
    logic [15:0] rel;
    logic [7:0] off;
    byte_t look;
    logic hit;

    always_comb
    begin
        addr_nxt = addr_r;
        space_nxt = space_r;
        if (i_load)
        begin
            addr_nxt = i_addr;
            space_nxt = i_space ? space_alt : space_sfdp;
        end
        else if (i_next)
        begin
            addr_nxt = addr_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // offset mapping
    always_comb
    begin
        rel = 16'h0000;
        case (space_nxt)
            space_sfdp: rel = addr_nxt - `TABLE_BASE;
            space_alt: rel = addr_nxt - {8'h00, `ALT_SHIFT};
            default: rel = 16'h0000;
        endcase
        off = (rel[15:8] == 8'h00) ? rel[7:0] : 8'h00;
    end

    param_rom_lookup u_lookup (
        .i_offset(off),
        .o_data(look),
        .o_hit(hit)
    );

    always_comb
    begin
        data_nxt = look;
        valid_nxt = hit && (rel[15:8] == 8'h00);
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            addr_r <= 16'h0000;
            space_r <= space_sfdp;
            data_r <= `BYTE_FILL;
            valid_r <= 1'b0;
        end
        else
        begin
            addr_r <= addr_nxt;
            space_r <= space_nxt;
            data_r <= data_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign o_data = data_r;
    assign o_valid = valid_r;
    assign o_addr = addr_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence load_quad_op_s;
        i_load && !i_space && i_addr == 16'h10AB;
    endsequence

    sequence two_nexts_s;
        !i_load && i_next ##1 !i_load && i_next;
    endsequence

    sequence load_below_s;
        i_load && !i_space && i_addr == 16'h109A;
    endsequence

    sequence load_dual_io_s;
        i_load && !i_space && i_addr == 16'h109E;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // address stepping
    incr_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_load && i_next |=> o_addr == $past(o_addr) + 16'h0001)
        else $error("address did not advance");

    load_wins_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load |=> o_addr == $past(i_addr))
        else $error("load address not taken");

    hold_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_load && !i_next |=> $stable(o_addr) && $stable(o_data) && $stable(o_valid))
        else $error("output moved while idle");

    addr_wrap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_load && i_next && o_addr == 16'hFFFF |=> o_addr == 16'h0000)
        else $error("address did not wrap");

    stream_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        load_dual_io_s ##1 two_nexts_s
        |=> o_data == 8'hFE && $past(o_data) == 8'hBB && $past(o_data, 2) == 8'h88)
        else $error("sequential stream out of order");

    ////////////////////////////////////////////////////////////////////////////
    // slice bounds
    slice_entry_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        load_below_s ##1 two_nexts_s |=> o_valid && !$past(o_valid))
        else $error("slice start misplaced");

    sfdp_exit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_load && i_next && space_r == space_sfdp && o_addr == 16'h10AB
        |=> !o_valid && o_data == 8'hFF)
        else $error("slice end misplaced");

    alt_exit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_load && i_next && space_r == space_alt && o_addr == 16'h001D
        |=> !o_valid && o_data == 8'hFF)
        else $error("alternate slice end misplaced");

    sfdp_range_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && space_r == space_sfdp |-> o_addr >= 16'h109C && o_addr <= 16'h10AB)
        else $error("valid outside slice");

    alt_range_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && space_r == space_alt |-> o_addr >= 16'h000E && o_addr <= 16'h001D)
        else $error("alternate valid outside slice");

    outside_fill_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !o_valid |-> o_data == 8'hFF)
        else $error("byte outside slice not fill");

    ////////////////////////////////////////////////////////////////////////////
    // byte values
    dual_out_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && !i_space && i_addr == 16'h109C |=> o_data == 8'hFF && o_valid)
        else $error("dual out field wrong");

    dual_out_op_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && !i_space && i_addr == 16'h109D |=> o_data == 8'hFF && o_valid)
        else $error("dual out opcode wrong");

    dual_io_cyc_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        load_dual_io_s |=> o_data == 8'h88 && o_valid)
        else $error("dual io cycle byte wrong");

    dual_io_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && !i_space && i_addr == 16'h109F |=> o_data == 8'hBB)
        else $error("dual io opcode wrong");

    qpi_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && !i_space && i_addr == 16'h10A0 |=> o_data == 8'hFE)
        else $error("flag byte wrong");

    rsvd_dword5_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && space_r == space_sfdp && o_addr >= 16'h10A1
        && o_addr <= 16'h10A5 |-> o_data == 8'hFF)
        else $error("reserved byte not fill");

    dual_all_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && !i_space && i_addr == 16'h10A6 |=> o_data == 8'hFF && o_valid)
        else $error("dual all field wrong");

    dual_all_op_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && !i_space && i_addr == 16'h10A7 |=> o_data == 8'hFF && o_valid)
        else $error("dual all opcode wrong");

    reserved_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && o_addr == 16'h10A8 && space_r == space_sfdp |-> o_data == 8'hFF)
        else $error("reserved byte not fill");

    rsvd_dword7_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && o_addr == 16'h10A9 && space_r == space_sfdp |-> o_data == 8'hFF)
        else $error("reserved byte not fill");

    qpi_cyc_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && !i_space && i_addr == 16'h10AA |=> o_data == 8'h48)
        else $error("quad cycle byte wrong");

    qpi_opcode_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        load_quad_op_s |=> o_data == 8'hEB && o_valid)
        else $error("quad opcode byte wrong");

    ////////////////////////////////////////////////////////////////////////////
    // alternate area
    alt_mirror_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_load && i_space && i_addr == 16'h0010 |=> o_data == 8'h88 && o_valid)
        else $error("alternate mirror wrong");

    alt_dual_op_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && space_r == space_alt && o_addr == 16'h0011 |-> o_data == 8'hBB)
        else $error("alternate dual io opcode wrong");

    alt_flags_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && space_r == space_alt && o_addr == 16'h0012 |-> o_data == 8'hFE)
        else $error("alternate flag byte wrong");

    alt_quad_cyc_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && space_r == space_alt && o_addr == 16'h001C |-> o_data == 8'h48)
        else $error("alternate quad cycle byte wrong");

    alt_quad_op_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_valid && space_r == space_alt && o_addr == 16'h001D |-> o_data == 8'hEB)
        else $error("alternate quad opcode wrong");
endmodule

// File: logic/param_rom_consts.svh
// Purpose: constants for the discoverable parameter slice rom
// Assumes: byte addresses are relative to the table base
// Notes: both address spaces share one set of contents
// Behaviour
// - offset 0Ch reads FFh, marking dual-output mode and dummy fields unused.
// - offset 0Dh reads FFh, no dual-output read opcode offered.
// - offset 0Eh reads 88h, four dual I/O mode cycles and eight dummy cycles.
// - offset 0Fh reads BBh, the dual I/O read opcode.
// - offset 10h reads FEh, four-wire command mode supported, no dual-all, reserved ones.
// - reserved offsets 11h to 15h, 18h and 19h read FFh.
// - offset 16h reads FFh, dual-all mode and dummy fields absent.
// - offset 17h reads FFh, no dual-all read opcode.
// - offset 1Ah reads 48h, two mode cycles and eight dummy cycles for four-wire quad read.
// - offset 1Bh reads EBh, the four-wire quad I/O read opcode.
// - the table begins at absolute address 1090h in the sfdp space and 0002h in the alternate space, and offsets count from there.
`ifndef PARAM_ROM_CONSTS_SVH
`define PARAM_ROM_CONSTS_SVH
`define TABLE_BASE 16'h1090
`define ALT_SHIFT 8'h02
`define SLICE_FIRST 8'h0C
`define SLICE_LAST 8'h1B
`define BYTE_FILL 8'hFF
`define BYTE_DUAL_IO_CYC 8'h88
`define BYTE_DUAL_IO_OP 8'hBB
`define BYTE_QPI_FLAGS 8'hFE
`define BYTE_QPI_CYC 8'h48
`define BYTE_QPI_OP 8'hEB
`endif

// File: logic/param_rom_lookup.sv
// Purpose: combinational byte lookup for the slice
// Assumes: offset is relative to the selected space's base, 1090h for sfdp and 0002h for the alternate space
// Notes: out-of-slice offsets read as fill
`timescale 1ns/1ps
`include "param_rom_consts.svh"
module param_rom_lookup
    import param_rom_pkg::*;
(
    input wire logic [7:0] i_offset,
    output byte_t o_data,
    output logic o_hit
);
    always_comb
    begin
        o_hit = (i_offset >= `SLICE_FIRST) && (i_offset <= `SLICE_LAST);
        case (i_offset)
            8'h0C: o_data = `BYTE_FILL;
            8'h0D: o_data = `BYTE_FILL;
            8'h0E: o_data = `BYTE_DUAL_IO_CYC;
            8'h0F: o_data = `BYTE_DUAL_IO_OP;
            8'h10: o_data = `BYTE_QPI_FLAGS;
            8'h16: o_data = `BYTE_FILL;
            8'h17: o_data = `BYTE_FILL;
            8'h1A: o_data = `BYTE_QPI_CYC;
            8'h1B: o_data = `BYTE_QPI_OP;
            default: o_data = `BYTE_FILL;
        endcase
    end
endmodule

// File: logic/param_rom_pkg.sv
// Purpose: types for the parameter slice rom
// Assumes: nothing
// Notes: none
package param_rom_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic {space_sfdp, space_alt} space_e;
endpackage

// File: sim/host_model.sv
// Purpose: host side reading the parameter slice
// Assumes: drives on falling edges
// Notes: released address shows inverted value
`timescale 1ns/1ps
module host_model (
    input wire logic i_clock,
    output logic o_load,
    output logic o_space,
    output logic [15:0] o_addr,
    output logic o_next
);
    logic [15:0] held;
    initial
    begin
        o_load = 1'b0;
        o_space = 1'b0;
        o_addr = 16'hFFFF;
        o_next = 1'b0;
        held = 16'h0000;
    end
    // each task is called just after a falling edge, drives one cycle, returns at the next
    // one load then sequential bytes
    task automatic start(input logic sp, input logic [15:0] a, input logic nx);
        o_load = 1'b1;
        o_space = sp;
        o_addr = a;
        o_next = nx;
        held = a;
        @(negedge i_clock);
    endtask
    task automatic step();
        o_load = 1'b0;
        o_addr = ~held;
        o_next = 1'b1;
        @(negedge i_clock);
    endtask
    task automatic halt();
        o_load = 1'b0;
        o_addr = ~held;
        o_next = 1'b0;
        @(negedge i_clock);
    endtask
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for the parameter slice rom
// Assumes: one cycle from load or advance to output
// Notes: expected bytes are worked out here
`timescale 1ns/1ps
module testbench;
    import param_rom_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic load, space, next;
    logic [15:0] addr, o_addr;
    byte_t o_data;
    logic o_valid;
    int n_fail = 0;
    int n_compared = 0;
    always #50 i_clock = ~i_clock;
    host_model i_host (.i_clock(i_clock), .o_load(load), .o_space(space), .o_addr(addr),
        .o_next(next));
    param_rom i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_load(load), .i_space(space),
        .i_addr(addr), .i_next(next), .o_data(o_data), .o_valid(o_valid), .o_addr(o_addr));
    function automatic logic [24:0] want(input logic sp, input logic [15:0] a);
        logic [15:0] r;
        logic [7:0] d;
        r = a - (sp ? 16'h0002 : 16'h1090);
        case (r)
            16'h000E: d = 8'h88;
            16'h000F: d = 8'hBB;
            16'h0010: d = 8'hFE;
            16'h001A: d = 8'h48;
            16'h001B: d = 8'hEB;
            default: d = 8'hFF;
        endcase
        return {r >= 16'h000C && r <= 16'h001B, d, a};
    endfunction
    task automatic check_out(input logic [24:0] exp);
        n_compared++;
        if ({o_valid, o_data, o_addr} !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, {o_valid, o_data, o_addr}, exp);
        end
    endtask
    task automatic sweep(input logic sp, input logic [15:0] a, input int n);
        i_host.start(sp, a, 1'b0);
        for (int k = 0; k < n; k++)
        begin
            check_out(want(sp, a + 16'(k)));
            i_host.step();
        end
        i_host.halt();
    endtask
    task automatic load_wins();
        i_host.start(1'b0, 16'h109E, 1'b1);
        check_out(want(1'b0, 16'h109E));
        i_host.start(1'b1, 16'h001D, 1'b0);
        check_out(want(1'b1, 16'h001D));
        i_host.start(1'b0, 16'hFFFF, 1'b0);
        i_host.step();
        i_host.halt();
        check_out(want(1'b0, 16'h0000));
    endtask
    task automatic spot_loads();
        i_host.start(1'b0, 16'h109C, 1'b0);
        check_out(want(1'b0, 16'h109C));
        i_host.start(1'b0, 16'h109D, 1'b0);
        check_out(want(1'b0, 16'h109D));
        i_host.start(1'b0, 16'h109F, 1'b0);
        check_out(want(1'b0, 16'h109F));
        i_host.start(1'b0, 16'h10A0, 1'b0);
        check_out(want(1'b0, 16'h10A0));
        i_host.start(1'b0, 16'h10A6, 1'b0);
        check_out(want(1'b0, 16'h10A6));
        i_host.start(1'b0, 16'h10A7, 1'b0);
        check_out(want(1'b0, 16'h10A7));
        i_host.start(1'b0, 16'h10AA, 1'b0);
        check_out(want(1'b0, 16'h10AA));
        i_host.start(1'b0, 16'h10AB, 1'b0);
        check_out(want(1'b0, 16'h10AB));
        i_host.start(1'b1, 16'h0010, 1'b0);
        check_out(want(1'b1, 16'h0010));
        i_host.halt();
    endtask
    task automatic reset_mid();
        i_host.start(1'b0, 16'h10AB, 1'b0);
        i_rst_n = 1'b0;
        #1;
        check_out({1'b0, 8'hFF, 16'h0000});
        @(negedge i_clock);
        i_rst_n = 1'b1;
        sweep(1'b0, 16'h10A8, 4);
    endtask
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge i_clock);
        i_rst_n = 1'b1;
        sweep(1'b0, 16'h109A, 20);
        sweep(1'b1, 16'h000C, 20);
        load_wins();
        spot_loads();
        sweep(1'b0, 16'h109E, 3);
        reset_mid();
        give_verdict();
    end
    initial
    begin
        #200000;
        n_fail++;
        give_verdict();
    end
endmodule
